// File: rtl/ocp_cmd_port.sv
// Register front end issuing manual commands to the OTP macro
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
// Operation
// - Start-up loader powers macro around config read
// - Aux B select follows bit 6 during command
// - Aux A select follows bit 5 during command
// - Mode select follows bit 4 during command
// - All-banks bit resets to one
// - Differential assist: even true, odd inverted
// - Mode writes copy low half uninverted
// - Mode register reads zero the top half
// - Byte enables reset all ones, assist only
// - Enables 3 and 2 guard upper bytes
// - Selector codes pick the read bus
// - Start strobe runs command, reads zero, locked
// - Busy high from start to completion
module ocp_cmd_port (
  input  wire logic        clk_sys,    // System clock
  input  wire logic        rst,        // Synchronous reset
  input  wire logic [7:0]  reg_addr,   // Register byte address
  input  wire logic [31:0] reg_wdata,  // Register write data
  input  wire logic        reg_wr,     // Write strobe
  input  wire logic        reg_rd,     // Read strobe
  output logic      [31:0] reg_rdata,  // Read data, cycle after strobe
  input  wire logic        boot_start, // Loader begins config read
  input  wire logic        boot_end,   // Loader finished config read
  input  wire logic [31:0] mac_q,      // Macro normal read data
  input  wire logic [31:0] mac_sr,     // Macro status bus
  input  wire logic [31:0] mac_rr,     // Macro second read bus
  input  wire logic [15:0] mac_mr,     // Main mode register value
  input  wire logic [15:0] mac_mra,    // Aux mode A value
  input  wire logic [15:0] mac_mrb,    // Aux mode B value
  output logic             mac_en,     // Macro enable
  output logic             mac_mrb_s,  // Aux mode B select
  output logic             mac_mra_s,  // Aux mode A select
  output logic             mac_msel,   // Mode select
  output logic             mac_allb,   // All banks select
  output logic [10:0]      mac_addr,   // Macro word address
  output logic [31:0]      mac_wdata,  // Macro write data
  output logic [31:0]      mac_bmask,  // Per-bit program enable
  output logic [3:0]       mac_cmd,    // Macro command code
  output logic             mac_pulse,  // Command pulse stage
  output logic             busy        // Manual command in flight
);
  // Reset image of the control byte: only all-banks set
  localparam logic [4:0] CTRL_RST5 = {4'h0, ocp_pkg::ALLB_RST};

  typedef struct packed {
    logic        en;        // Macro enable by software
    logic        mrb;       // Aux B select
    logic        mra;       // Aux A select
    logic        msel;      // Mode select
    logic        allb;      // All banks
    logic [10:0] addr;      // Command address
    logic [31:0] wdata;     // Write word
    logic [3:0]  be;        // Program byte enables
    logic [2:0]  sel;       // Read bus select
    logic [7:0]  key;       // Protection key
    logic [3:0]  cmd;       // Command code
    logic        pgm_mode;  // 1 single, 0 differential
    logic        busy;      // Command in flight
    logic        boot_en;   // Loader holds macro on
    logic [31:0] rdata;     // Bus read data
    logic        m_en;      // Macro pins, registered
    logic        m_mrb;
    logic        m_mra;
    logic        m_msel;
    logic        m_allb;
    logic [10:0] m_addr;
    logic [31:0] m_wdata;
    logic [31:0] m_bmask;
    logic [3:0]  m_cmd;
    logic        m_pulse;
  } ocp_top_st_t;

  ocp_top_st_t st_ff, nxt_st;

  logic        go;        // Accepted start strobe
  logic        seq_pulse; // Sequencer pulse stage
  logic        seq_odd;   // Sequencer on odd word
  logic        seq_done;  // Sequencer finished
  logic [31:0] rd_word;   // Selected read bus word
  logic [31:0] be_mask;   // Byte enables spread to bits
  logic        is_pgma;   // Current command is assist
  logic        is_mode;   // Current command writes a mode register
  logic        wr_start;  // Write hits start strobe with a one

  // Spread each byte enable over its byte
  for (genvar g = 0; g < ocp_pkg::BE_W; g++) begin : g_be
    assign be_mask[8*g +: 8] = {8{st_ff.be[g]}};
  end

  assign is_pgma = (st_ff.cmd == ocp_pkg::CMD_PGMA);
  assign is_mode = (st_ff.cmd == ocp_pkg::CMD_AUX) ||
                   (st_ff.cmd == ocp_pkg::CMD_WRITE && st_ff.msel);
  assign wr_start = reg_wr && (reg_addr == ocp_pkg::OFS_START) &&
                    reg_wdata[ocp_pkg::START_BIT];
  // Locked key or a running command drops the strobe
  assign go = wr_start && !st_ff.busy &&
              (st_ff.key == ocp_pkg::KEY_UNLOCK);

  ocp_seq #(
    .PULSE (ocp_pkg::PULSE_CYC),
    .RECOV (ocp_pkg::RECOV_CYC)
  ) u_seq (
    .clk_sys (clk_sys),
    .rst     (rst),
    .go      (go),
    .pair    (is_pgma && !st_ff.pgm_mode),
    .pulse   (seq_pulse),
    .odd     (seq_odd),
    .done    (seq_done)
  );

  ocp_rdmux u_rdmux (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sel     (st_ff.sel),
    .q       (mac_q),
    .sr      (mac_sr),
    .rr      (mac_rr),
    .mr      (mac_mr),
    .mra     (mac_mra),
    .mrb     (mac_mrb),
    .rdata   (rd_word)
  );

  // Register writes, command control and macro pin drive
  always_comb begin
    nxt_st = st_ff;
    // Writes are held off while a command runs so pins stay stable
    if (reg_wr && !st_ff.busy) begin
      case (reg_addr)
        ocp_pkg::OFS_CTRL: begin
          nxt_st.en   = reg_wdata[ocp_pkg::CTRL_EN];
          nxt_st.mrb  = reg_wdata[ocp_pkg::CTRL_MRB];
          nxt_st.mra  = reg_wdata[ocp_pkg::CTRL_MRA];
          nxt_st.msel = reg_wdata[ocp_pkg::CTRL_MSEL];
          nxt_st.allb = reg_wdata[ocp_pkg::CTRL_ALLB];
        end
        ocp_pkg::OFS_ADDR:
          nxt_st.addr = reg_wdata[ocp_pkg::ADDR_W-1:0];
        ocp_pkg::OFS_WDATA: nxt_st.wdata = reg_wdata;
        ocp_pkg::OFS_DSEL: begin
          nxt_st.be  = reg_wdata[ocp_pkg::BE_LSB +: ocp_pkg::BE_W];
          nxt_st.sel = reg_wdata[ocp_pkg::SEL_W-1:0];
        end
        ocp_pkg::OFS_KEY: nxt_st.key = reg_wdata[7:0];
        ocp_pkg::OFS_CMD: begin
          nxt_st.cmd      = reg_wdata[ocp_pkg::CMD_W-1:0];
          nxt_st.pgm_mode = reg_wdata[ocp_pkg::PGM_MODE];
        end
        default: ;
      endcase
    end
    // Busy spans start to completion
    if (go) nxt_st.busy = 1'b1;
    else if (seq_done) nxt_st.busy = 1'b0;
    // Loader powers the macro around its read
    if (boot_start) nxt_st.boot_en = 1'b1;
    else if (boot_end) nxt_st.boot_en = 1'b0;
    nxt_st.m_en = st_ff.en | st_ff.boot_en;
    // Aux and mode selects follow control only while a command runs; all banks always
    nxt_st.m_mrb  = st_ff.busy & st_ff.mrb;
    nxt_st.m_mra  = st_ff.busy & st_ff.mra;
    nxt_st.m_msel = st_ff.busy & st_ff.msel;
    nxt_st.m_allb = st_ff.allb;
    nxt_st.m_cmd  = st_ff.cmd;
    nxt_st.m_pulse = seq_pulse;
    nxt_st.m_addr  = st_ff.addr;
    nxt_st.m_wdata = st_ff.wdata;
    nxt_st.m_bmask = {32{1'b1}};
    if (is_pgma) begin
      // Enables matter only for assist
      nxt_st.m_bmask = be_mask;
      if (!st_ff.pgm_mode) begin
        // Pair: even true, odd inverted, bit 0 ignored
        nxt_st.m_addr  = {st_ff.addr[ocp_pkg::ADDR_W-1:1], seq_odd};
        nxt_st.m_wdata = seq_odd ? ~st_ff.wdata : st_ff.wdata;
      end
    end else if (is_mode) begin
      // Low half passes as written, top cleared
      nxt_st.m_wdata = {16'h0000, st_ff.wdata[15:0]};
    end
    // Read data stands only in the cycle after the strobe
    nxt_st.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        ocp_pkg::OFS_CTRL: begin
          nxt_st.rdata[ocp_pkg::CTRL_EN]   = st_ff.en;
          nxt_st.rdata[ocp_pkg::CTRL_MRB]  = st_ff.mrb;
          nxt_st.rdata[ocp_pkg::CTRL_MRA]  = st_ff.mra;
          nxt_st.rdata[ocp_pkg::CTRL_MSEL] = st_ff.msel;
          nxt_st.rdata[ocp_pkg::CTRL_ALLB] = st_ff.allb;
        end
        ocp_pkg::OFS_ADDR:
          nxt_st.rdata[ocp_pkg::ADDR_W-1:0] = st_ff.addr;
        ocp_pkg::OFS_WDATA: nxt_st.rdata = st_ff.wdata;
        ocp_pkg::OFS_RDATA: nxt_st.rdata = rd_word;
        ocp_pkg::OFS_DSEL: begin
          nxt_st.rdata[ocp_pkg::BE_LSB +: ocp_pkg::BE_W] = st_ff.be;
          nxt_st.rdata[ocp_pkg::SEL_W-1:0] = st_ff.sel;
        end
        ocp_pkg::OFS_KEY: nxt_st.rdata[7:0] = st_ff.key;
        ocp_pkg::OFS_CMD: begin
          nxt_st.rdata[ocp_pkg::CMD_W-1:0] = st_ff.cmd;
          nxt_st.rdata[ocp_pkg::PGM_MODE]  = st_ff.pgm_mode;
        end
        ocp_pkg::OFS_STS: begin
          nxt_st.rdata[ocp_pkg::STS_BUSY] = st_ff.busy;
          nxt_st.rdata[ocp_pkg::STS_MEN]  = st_ff.m_en;
        end
        // Start strobe and unmapped words read zero
        default: ;
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff      <= '0;
      {st_ff.en, st_ff.mrb, st_ff.mra, st_ff.msel,
       st_ff.allb} <= CTRL_RST5;
      st_ff.be   <= ocp_pkg::BE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = st_ff.rdata;
  assign mac_en    = st_ff.m_en;
  assign mac_mrb_s = st_ff.m_mrb;
  assign mac_mra_s = st_ff.m_mra;
  assign mac_msel  = st_ff.m_msel;
  assign mac_allb  = st_ff.m_allb;
  assign mac_addr  = st_ff.m_addr;
  assign mac_wdata = st_ff.m_wdata;
  assign mac_bmask = st_ff.m_bmask;
  assign mac_cmd   = st_ff.m_cmd;
  assign mac_pulse = st_ff.m_pulse;
  assign busy      = st_ff.busy;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_start_busy;
    go |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy not raised on start");

  property p_locked;
    (wr_start && !busy && st_ff.key != ocp_pkg::KEY_UNLOCK) |=> !busy;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked start ran a command");

  property p_busy_hold;
    (busy && !seq_done) |=> busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");

  property p_mrb_pin;
    ##1 (mac_mrb_s == $past(st_ff.busy && st_ff.mrb));
  endproperty
  a_mrb_pin: assert property (p_mrb_pin)
    else $error("aux B select wrong");

  property p_mra_pin;
    ##1 (mac_mra_s == $past(st_ff.busy && st_ff.mra));
  endproperty
  a_mra_pin: assert property (p_mra_pin)
    else $error("aux A select wrong");

  property p_odd_inv;
    (mac_pulse && mac_cmd == ocp_pkg::CMD_PGMA && !st_ff.pgm_mode
     && mac_addr[0]) |-> (mac_wdata == ~st_ff.wdata);
  endproperty
  a_odd_inv: assert property (p_odd_inv)
    else $error("odd word not inverted");

  property p_top_bytes;
    (mac_pulse && mac_cmd == ocp_pkg::CMD_PGMA) |->
      (mac_bmask[31:24] == {8{st_ff.be[3]}}) &&
      (mac_bmask[23:16] == {8{st_ff.be[2]}});
  endproperty
  a_top_bytes: assert property (p_top_bytes)
    else $error("upper byte enable mapping wrong");

  property p_rd_one_cycle;
    !reg_rd |=> (reg_rdata == 32'h0000_0000);
  endproperty
  a_rd_one_cycle: assert property (p_rd_one_cycle)
    else $error("read data outside its cycle");

  property p_boot_on;
    boot_start |=> ##1 mac_en;
  endproperty
  a_boot_on: assert property (p_boot_on)
    else $error("macro not enabled for loader");
endmodule : ocp_cmd_port

// File: shared/ocp_pkg.sv
// Shared constants for the OTP manual command port
package ocp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_ADDR  = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_DSEL  = 8'h10;
  localparam logic [7:0] OFS_KEY   = 8'h14;
  localparam logic [7:0] OFS_START = 8'h18;
  localparam logic [7:0] OFS_STS   = 8'h1C;
  localparam logic [7:0] OFS_CMD   = 8'h20;
  // Control register fields
  localparam int CTRL_EN   = 7;
  localparam int CTRL_MRB  = 6;
  localparam int CTRL_MRA  = 5;
  localparam int CTRL_MSEL = 4;
  localparam int CTRL_ALLB = 3;
  localparam logic ALLB_RST = 1'h1;
  // Address field width
  localparam int ADDR_W = 11;
  // Data select fields
  localparam int BE_LSB = 4;
  localparam int BE_W   = 4;
  localparam logic [3:0] BE_RST = 4'hF;
  localparam int SEL_W  = 3;
  // Command register fields
  localparam int CMD_W    = 4;
  localparam int PGM_MODE = 4;
  // Status register fields
  localparam int STS_BUSY = 0;
  localparam int STS_MEN  = 1;
  // Start strobe bit and unlock key
  localparam int START_BIT = 0;
  localparam logic [7:0] KEY_UNLOCK = 8'h97;
  // Command codes
  localparam logic [3:0] CMD_WRITE = 4'h7;
  localparam logic [3:0] CMD_AUX   = 4'hB;
  localparam logic [3:0] CMD_PGMA  = 4'hE;
  // Read bus select codes
  localparam logic [2:0] SEL_Q   = 3'h0;
  localparam logic [2:0] SEL_SR  = 3'h1;
  localparam logic [2:0] SEL_RR  = 3'h2;
  localparam logic [2:0] SEL_MR  = 3'h3;
  localparam logic [2:0] SEL_MRA = 3'h4;
  localparam logic [2:0] SEL_MRB = 3'h5;
  // Command stage timing
  localparam int CLK_PS      = 25000;
  localparam int T_PULSE_PS  = 50000;
  localparam int T_RECOV_PS  = 65900;
  localparam int PULSE_CYC   = (T_PULSE_PS + CLK_PS - 1) / CLK_PS;
  localparam int RECOV_CYC   = (T_RECOV_PS + CLK_PS - 1) / CLK_PS;
endpackage : ocp_pkg

// File: rtl/ocp_seq.sv
// Stage sequencer for one manual command to the memory macro
`timescale 1ns/1ps
module ocp_seq #(
  parameter int PULSE = ocp_pkg::PULSE_CYC, // Pulse stage cycles
  parameter int RECOV = ocp_pkg::RECOV_CYC  // Recovery stage cycles
) (
  input  wire logic clk_sys, // System clock
  input  wire logic rst,     // Synchronous reset
  input  wire logic go,      // Start one command
  input  wire logic pair,    // Two-word differential program
  output logic      pulse,   // Pulse stage active
  output logic      odd,     // Second word of a pair
  output logic      done     // Command finished, one cycle
);
  // Counts must fit the 8-bit stage counter
  if (PULSE < 1 || PULSE > 255 || RECOV < 1 || RECOV > 255) begin : g_bad
    $error("ocp_seq: stage counts must be 1..255");
  end

  typedef enum logic [1:0] {S_IDLE, S_PULSE, S_RECOV} ocp_stage_t;

  typedef struct packed {
    ocp_stage_t stage; // Current stage
    logic [7:0] cnt;   // Cycles left in stage after this one
    logic       odd;   // Working on odd word
    logic       pair;  // Pair requested
    logic       done;  // Completion pulse
  } ocp_seq_st_t;

  ocp_seq_st_t st_ff, nxt_st;

  // Next state of the stage walk
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.stage)
      S_IDLE: begin
        if (go) begin
          nxt_st.stage = S_PULSE;
          nxt_st.cnt   = 8'(PULSE - 1);
          nxt_st.odd   = 1'b0;
          nxt_st.pair  = pair;
        end
      end
      S_PULSE: begin
        if (st_ff.cnt == 8'h00) begin
          nxt_st.stage = S_RECOV;
          nxt_st.cnt   = 8'(RECOV - 1);
        end else nxt_st.cnt = st_ff.cnt - 8'h01;
      end
      S_RECOV: begin
        if (st_ff.cnt != 8'h00) nxt_st.cnt = st_ff.cnt - 8'h01;
        else if (st_ff.pair && !st_ff.odd) begin
          // Even word done, odd word follows
          nxt_st.stage = S_PULSE;
          nxt_st.cnt   = 8'(PULSE - 1);
          nxt_st.odd   = 1'b1;
        end else begin
          nxt_st.stage = S_IDLE;
          nxt_st.done  = 1'b1;
        end
      end
      default: nxt_st.stage = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign pulse = (st_ff.stage == S_PULSE);
  assign odd   = st_ff.odd;
  assign done  = st_ff.done;
endmodule : ocp_seq

// File: rtl/ocp_rdmux.sv
// Read bus selector feeding the read word register
`timescale 1ns/1ps
module ocp_rdmux (
  input  wire logic        clk_sys, // System clock
  input  wire logic        rst,     // Synchronous reset
  input  wire logic [2:0]  sel,     // Read bus select
  input  wire logic [31:0] q,       // Normal read data
  input  wire logic [31:0] sr,      // Status bus
  input  wire logic [31:0] rr,      // Second read bus
  input  wire logic [15:0] mr,      // Main mode register
  input  wire logic [15:0] mra,     // Aux mode A
  input  wire logic [15:0] mrb,     // Aux mode B
  output logic      [31:0] rdata    // Registered read word
);
  typedef struct packed {
    logic [31:0] rdata; // Captured word
  } ocp_rd_st_t;

  ocp_rd_st_t st_ff, nxt_st;

  // Route one bus; mode registers are zero extended
  always_comb begin
    nxt_st = st_ff;
    case (sel)
      ocp_pkg::SEL_Q:   nxt_st.rdata = q;
      ocp_pkg::SEL_SR:  nxt_st.rdata = sr;
      ocp_pkg::SEL_RR:  nxt_st.rdata = rr;
      ocp_pkg::SEL_MR:  nxt_st.rdata = {16'h0000, mr};
      ocp_pkg::SEL_MRA: nxt_st.rdata = {16'h0000, mra};
      ocp_pkg::SEL_MRB: nxt_st.rdata = {16'h0000, mrb};
      default:          nxt_st.rdata = 32'h0000_0000;
    endcase
  end

  // Capture register
  always_ff @(posedge clk_sys) begin
    if (rst) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign rdata = st_ff.rdata;

  property p_sel_mrb;
    @(posedge clk_sys) disable iff (rst)
    (sel == ocp_pkg::SEL_MRB) |=> (rdata == {16'h0000, $past(mrb)});
  endproperty
  a_sel_mrb: assert property (p_sel_mrb)
    else $error("aux B not zero extended");
endmodule : ocp_rdmux

// File: bench/ocp_macro_model.sv
// Behavioural model of the programmable memory macro behind the port
`timescale 1ns/1ps
module ocp_macro_model #(
  parameter logic [31:0] SR_VAL = 32'h3C00_0081 // Fixed status pattern
) (
  input  wire logic        clk_sys, // System clock
  input  wire logic        en,      // Macro enable
  input  wire logic        mrb_s,   // Aux mode B select
  input  wire logic        mra_s,   // Aux mode A select
  input  wire logic        msel,    // Mode select
  input  wire logic [10:0] addr,    // Word address
  input  wire logic [31:0] wdata,   // Write data
  input  wire logic [31:0] bmask,   // Per-bit program enable
  input  wire logic [3:0]  cmd,     // Command code
  input  wire logic        pulse,   // Pulse stage
  output logic      [31:0] q,       // Normal read data
  output logic      [31:0] sr,      // Status bus
  output logic      [31:0] rr,      // Second read bus
  output logic      [15:0] mr,      // Main mode register
  output logic      [15:0] mra,     // Aux mode A
  output logic      [15:0] mrb      // Aux mode B
);
  logic [31:0] mem [0:2047]; // Word array, blank at start
  logic [31:0] dreg;         // Data register of plain writes
  logic        pls_q;        // Pulse seen last cycle

  // Blank array and mode registers
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 32'h0000_0000;
    mr    = 16'h0000;
    mra   = 16'h0000;
    mrb   = 16'h0000;
    pls_q = 1'b0;
    dreg  = 32'h0000_0000;
  end

  // Disabled macro shows inverted data, not stale values
  assign q  = en ? mem[addr] : ~mem[addr];
  // Second bus exposes the data register of plain writes
  assign rr = dreg;
  assign sr = en ? SR_VAL : ~SR_VAL;

  // Act once per pulse stage; nothing happens while disabled
  always @(posedge clk_sys) begin
    pls_q <= pulse;
    if (pulse && !pls_q && en) begin
      case (cmd)
        ocp_pkg::CMD_WRITE: begin
          if (msel) mr <= wdata[15:0];
          // Software already inverted the word it wants burned
          else dreg <= wdata;
        end
        ocp_pkg::CMD_AUX: begin
          if (mra_s) mra <= wdata[15:0];
          if (mrb_s) mrb <= wdata[15:0];
        end
        // Fuses only ever go from 0 to 1
        ocp_pkg::CMD_PGMA: mem[addr] <= mem[addr] | (wdata & bmask);
        default: ;
      endcase
    end
  end
endmodule : ocp_macro_model

// File: bench/ocp_cmd_port_bench.sv
// Self-checking bench for the manual command port
`timescale 1ns/1ps
module ocp_cmd_port_bench;
  localparam logic [31:0] SR_VAL = 32'h3C00_0081; // Model status pattern
  logic        clk_sys, rst;             // Clock and reset
  logic [7:0]  reg_addr;                 // Register address
  logic [31:0] reg_wdata, reg_rdata;     // Register data
  logic        reg_wr, reg_rd;           // Strobes
  logic        boot_start, boot_end;     // Loader pulses
  logic [31:0] q, sr, rr, bmask, wdat;   // Macro buses
  logic [15:0] mr, mra, mrb;             // Mode registers
  logic        en, mrb_s, mra_s, msel;   // Macro selects
  logic        allb, pls, busy;          // Bank, pulse, busy
  logic [10:0] maddr;                    // Macro address
  logic [3:0]  mcmd;                     // Macro command
  int          n_fail, compares, cyc;    // Counters

  ocp_cmd_port ocp_cmd_port_i (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_start(boot_start),
    .boot_end(boot_end), .mac_q(q), .mac_sr(sr), .mac_rr(rr),
    .mac_mr(mr), .mac_mra(mra), .mac_mrb(mrb), .mac_en(en),
    .mac_mrb_s(mrb_s), .mac_mra_s(mra_s), .mac_msel(msel),
    .mac_allb(allb), .mac_addr(maddr), .mac_wdata(wdat),
    .mac_bmask(bmask), .mac_cmd(mcmd), .mac_pulse(pls), .busy(busy));

  ocp_macro_model #(.SR_VAL(SR_VAL)) ocp_macro_model_i (.clk_sys(clk_sys),
    .en(en), .mrb_s(mrb_s), .mra_s(mra_s), .msel(msel), .addr(maddr),
    .wdata(wdat), .bmask(bmask), .cmd(mcmd), .pulse(pls), .q(q),
    .sr(sr), .rr(rr), .mr(mr), .mra(mra), .mrb(mrb));

  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic print_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // Compare one 32-bit result
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : chk

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Register read; read word lags the macro buses, so let it settle
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    if (a == ocp_pkg::OFS_RDATA) repeat (3) @(posedge clk_sys);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rc

  // Start a command and wait, bounded, for completion
  task automatic run();
    int n;
    n = 0;
    wr(ocp_pkg::OFS_START, 32'h0000_0001);
    rc(ocp_pkg::OFS_STS, 32'h0000_0003);
    while (busy !== 1'b0 && n < 40) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk({31'h0, busy}, 32'h0000_0000);
  endtask : run

  // Hang guard; a normal run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    {n_fail, compares, cyc} = '0;
    rst        = 1'b1;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0000_0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    boot_start = 1'b0;
    boot_end   = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, reserved bits, unmapped place
    rc(ocp_pkg::OFS_CTRL, 32'h0000_0008);
    chk({31'h0, allb}, 32'h0000_0001);
    rc(ocp_pkg::OFS_DSEL, 32'h0000_00F0);
    rc(ocp_pkg::OFS_ADDR, 32'h0000_0000);
    rc(8'h40, 32'h0000_0000);
    wr(ocp_pkg::OFS_CTRL, 32'hFFFF_FFFF);
    rc(ocp_pkg::OFS_CTRL, 32'h0000_00F8);
    wr(ocp_pkg::OFS_ADDR, 32'hFFFF_FFFF);
    rc(ocp_pkg::OFS_ADDR, 32'h0000_07FF);
    wr(ocp_pkg::OFS_DSEL, 32'hFFFF_FFFF);
    rc(ocp_pkg::OFS_DSEL, 32'h0000_00F7);
    // Start while locked must do nothing
    wr(ocp_pkg::OFS_CTRL, 32'h0000_0098);
    wr(ocp_pkg::OFS_WDATA, 32'h1234_ABCD);
    wr(ocp_pkg::OFS_CMD, {28'h0, ocp_pkg::CMD_WRITE});
    wr(ocp_pkg::OFS_DSEL, 32'h0000_0003);
    wr(ocp_pkg::OFS_START, 32'h0000_0001);
    rc(ocp_pkg::OFS_STS, 32'h0000_0002);
    rc(ocp_pkg::OFS_START, 32'h0000_0000);
    rc(ocp_pkg::OFS_RDATA, 32'h0000_0000);
    // Unlock, then main mode write
    wr(ocp_pkg::OFS_KEY, {24'h0, ocp_pkg::KEY_UNLOCK});
    run();
    rc(ocp_pkg::OFS_RDATA, 32'h0000_ABCD);
    // Aux updates, A only then B only
    wr(ocp_pkg::OFS_CTRL, 32'h0000_00A8);
    wr(ocp_pkg::OFS_WDATA, 32'hFFFF_2222);
    wr(ocp_pkg::OFS_CMD, {28'h0, ocp_pkg::CMD_AUX});
    run();
    wr(ocp_pkg::OFS_CTRL, 32'h0000_00C8);
    wr(ocp_pkg::OFS_WDATA, 32'hEEEE_3333);
    run();
    // Plain write leaves the main mode register alone
    wr(ocp_pkg::OFS_CTRL, 32'h0000_0088);
    wr(ocp_pkg::OFS_CMD, {28'h0, ocp_pkg::CMD_WRITE});
    run();
    rc(ocp_pkg::OFS_RDATA, 32'h0000_ABCD);
    wr(ocp_pkg::OFS_DSEL, 32'h0000_0004);
    rc(ocp_pkg::OFS_RDATA, 32'h0000_2222);
    wr(ocp_pkg::OFS_DSEL, 32'h0000_0005);
    rc(ocp_pkg::OFS_RDATA, 32'h0000_3333);
    // Differential assist at an odd address, bytes 2 and 0
    wr(ocp_pkg::OFS_ADDR, 32'h0000_0013);
    wr(ocp_pkg::OFS_WDATA, 32'h8765_4321);
    wr(ocp_pkg::OFS_DSEL, 32'h0000_0050);
    wr(ocp_pkg::OFS_CMD, {28'h0, ocp_pkg::CMD_PGMA});
    run();
    rc(ocp_pkg::OFS_RDATA, 32'h009A_00DE);
    // Second bus holds the word of the plain write as written
    wr(ocp_pkg::OFS_DSEL, 32'h0000_0052);
    rc(ocp_pkg::OFS_RDATA, ~32'h1111_CCCC);
    wr(ocp_pkg::OFS_DSEL, 32'h0000_0051);
    rc(ocp_pkg::OFS_RDATA, SR_VAL);
    // Leave differential mode so address bit 0 reaches the macro again
    wr(ocp_pkg::OFS_CMD, {28'h0, ocp_pkg::CMD_PGMA} | 32'h0000_0010);
    wr(ocp_pkg::OFS_ADDR, 32'h0000_0012);
    wr(ocp_pkg::OFS_DSEL, 32'h0000_0050);
    rc(ocp_pkg::OFS_RDATA, 32'h0065_0021);
    // Single-word assist, bytes 3 and 1
    wr(ocp_pkg::OFS_ADDR, 32'h0000_0020);
    wr(ocp_pkg::OFS_DSEL, 32'h0000_00A0);
    wr(ocp_pkg::OFS_CMD, {28'h0, ocp_pkg::CMD_PGMA} | 32'h0000_0010);
    run();
    rc(ocp_pkg::OFS_RDATA, 32'h8700_4300);
    wr(ocp_pkg::OFS_ADDR, 32'h0000_0021);
    rc(ocp_pkg::OFS_RDATA, 32'h0000_0000);
    // Loader holds the macro on around its read
    wr(ocp_pkg::OFS_CTRL, 32'h0000_0008);
    repeat (3) @(posedge clk_sys);
    #1 chk({31'h0, en}, 32'h0000_0000);
    @(posedge clk_sys);
    boot_start <= 1'b1;
    @(posedge clk_sys);
    boot_start <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk({31'h0, en}, 32'h0000_0001);
    @(posedge clk_sys);
    boot_end <= 1'b1;
    @(posedge clk_sys);
    boot_end <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk({31'h0, en}, 32'h0000_0000);
    print_verdict();
  end
endmodule : ocp_cmd_port_bench
